// [design/dpcsr_pkg.sv]
// constants for the dual port configuration and session register bank
// assumes byte 0 of a page or word sits in bits 7:0
package dpcsr_pkg;
	// rf page and sector addresses
	localparam logic [1:0] SECTOR_MAIN   = 2'h0;
	localparam logic [1:0] SECTOR_MIRROR = 2'h3;
	localparam logic [7:0] PAGE_CFG0     = 8'he8;
	localparam logic [7:0] PAGE_CFG1     = 8'he9;
	localparam logic [7:0] PAGE_SES0     = 8'hec;
	localparam logic [7:0] PAGE_SES1     = 8'hed;
	localparam logic [7:0] PAGE_MIR0     = 8'hf8;
	localparam logic [7:0] PAGE_MIR1     = 8'hf9;
	// i2c block addresses
	localparam logic [7:0] BLOCK_CFG     = 8'h3a;
	localparam logic [7:0] BLOCK_SES     = 8'hfe;
	// byte positions inside the eight byte sets
	localparam logic [2:0] BYTE_CTRL     = 3'h0;
	localparam logic [2:0] BYTE_MSGEND   = 3'h1;
	localparam logic [2:0] BYTE_LOCK     = 3'h6;
	localparam logic [2:0] BYTE_STATUS   = 3'h6;
	// control byte fields
	localparam int CTRL_MUTE_BIT   = 7;
	localparam int CTRL_RELAY_BIT  = 6;
	localparam int CTRL_REL_LSB    = 4;
	localparam int CTRL_ASSERT_LSB = 2;
	localparam int CTRL_DIR_BIT    = 0;
	// lock and status bits
	localparam int LOCK_RF_BIT      = 0;
	localparam int LOCK_I2C_BIT     = 1;
	localparam int STAT_FIELD_BIT   = 0;
	localparam int STAT_MSGREAD_BIT = 1;
	// field pin event selections
	localparam logic [1:0] SEL_FIELD = 2'h0;
	localparam logic [1:0] SEL_ALT1  = 2'h1;
	localparam logic [1:0] SEL_ALT2  = 2'h2;
	localparam logic [1:0] SEL_RELAY = 2'h3;
	// values after reset
	localparam logic [7:0] SES_RESET    = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
	localparam logic [127:0] BLOCK_RESET = 128'h0;
	// default set contents before their first write
	localparam logic [7:0] CFG_ERASED   = 8'h00;
	typedef enum logic {DPCSR_LOAD, DPCSR_RUN} dpcsr_state_t;
endpackage

// [design/dpcsr_regs.sv]
// dual port configuration and session register bank, rf and i2c ports
// assumes all request and event inputs come from logic on clk_sys
// Notes on behaviour
// RULE1: defaults live at rf pages e8h/e9h sector 0 and i2c block 3ah.
// RULE2: default set is non-volatile and supplies settings after power-on.
// RULE3: both ports read and write defaults unless a lock bit forbids.
// RULE4: session set lives at rf pages ech/edh sector 0, i2c block feh.
// RULE5: session set is read-only from rf, read-write from i2c.
// RULE6: session set also mirrored read-only at rf pages f8h/f9h sector 3.
// RULE7: lock byte only in defaults, status byte only in session set.
// RULE8: power-on reset copies defaults into the session set.
// RULE9: session writes act at once and last until next power-on.
// RULE10: default writes leave current behaviour unchanged until power-on.
// RULE11: i2c reaches session bytes only through register operations.
// RULE12: control bit 7 enables rf mute and repeated-start soft reset.
// RULE13: control bit 6 enables relay mode with buffer mapped.
// RULE14: bits 5-4 pick release: field off, halt, or last message page.
// RULE15: release 11b with assert 11b adds last i2c data read/written.
// RULE16: assert select picks field on, start, selection, or relay data.
// RULE17: rf read of last page of message end block sets read flag.
// RULE18: simultaneous accesses are served one at a time, whole values.
`timescale 1ns/1ps
module dpcsr_regs
(
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic         rf_req,
	input  wire logic         rf_we,
	input  wire logic [1:0]   rf_sector,
	input  wire logic [7:0]   rf_page,
	input  wire logic [31:0]  rf_wdata,
	output logic              rf_ack,
	output logic              rf_err,
	output logic [31:0]       rf_rdata,
	input  wire logic         i2c_req,
	input  wire logic         i2c_we,
	input  wire logic [7:0]   i2c_block,
	input  wire logic [127:0] i2c_wdata,
	output logic              i2c_ack,
	output logic              i2c_err,
	output logic [127:0]      i2c_rdata,
	input  wire logic         i2c_reg_req,
	input  wire logic         i2c_reg_we,
	input  wire logic [2:0]   i2c_reg_addr,
	input  wire logic [7:0]   i2c_reg_mask,
	input  wire logic [7:0]   i2c_reg_wdata,
	output logic              i2c_reg_ack,
	output logic [7:0]        i2c_reg_rdata,
	input  wire logic         field_on_evt,
	input  wire logic         field_off_evt,
	input  wire logic         soc_evt,
	input  wire logic         select_evt,
	input  wire logic         halt_evt,
	input  wire logic         relay_ready_evt,
	input  wire logic         relay_taken_evt,
	input  wire logic         i2c_last_read_evt,
	input  wire logic         i2c_last_write_evt,
	input  wire logic         i2c_rep_start_evt,
	output logic              rf_mute_softreset_enable,
	output logic              relay_mode_enable,
	output logic              soft_reset_pulse,
	output logic              field_detect_output_o,
	output logic              field_detect_output_oe
);

	// non-volatile default bytes: no reset, erased until first written
	logic [7:0]                 cfg [0:7] = '{default: dpcsr_pkg::CFG_ERASED};
	logic [7:0]                 ses [0:7];
	logic [7:0]                 status;
	dpcsr_pkg::dpcsr_state_t    state;
	logic                       prefer_rf;
	function automatic logic [31:0] word_of(input logic [7:0] b0,
		input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
		word_of = {b3, b2, b1, b0};
	endfunction

	// request decode
	logic                       rf_pend;
	logic                       i2c_pend;
	logic                       reg_pend;
	logic                       i2c_side;
	logic                       take_rf;
	logic                       take_blk;
	logic                       take_reg;
	logic                       run;
	logic                       rf_cfg_hit;
	logic                       rf_ses_hit;
	logic                       rf_hi;
	logic                       rf_cfg_wr;
	logic                       blk_cfg_wr;
	logic                       reg_wr;
	logic                       rf_last_page;
	logic [7:0]                 ctrl;
	logic [7:0]                 msg_end;
	assign run       = (state == dpcsr_pkg::DPCSR_RUN);
	assign rf_pend   = rf_req && !rf_ack;
	assign i2c_pend  = i2c_req && !i2c_ack;
	assign reg_pend  = i2c_reg_req && !i2c_reg_ack && !i2c_pend;
	assign i2c_side  = i2c_pend || reg_pend;
	// one access per cycle, alternating when both ports contend
	assign take_rf   = run && rf_pend && (!i2c_side || prefer_rf); // see RULE18
	assign take_blk  = run && i2c_pend && !take_rf; // see RULE18
	assign take_reg  = run && reg_pend && !take_rf;
	assign rf_cfg_hit = (rf_sector == dpcsr_pkg::SECTOR_MAIN) &&
		(rf_page == dpcsr_pkg::PAGE_CFG0 || rf_page == dpcsr_pkg::PAGE_CFG1);
	assign rf_ses_hit = ((rf_sector == dpcsr_pkg::SECTOR_MAIN) &&
		(rf_page == dpcsr_pkg::PAGE_SES0 ||
		rf_page == dpcsr_pkg::PAGE_SES1)) || // see RULE4
		((rf_sector == dpcsr_pkg::SECTOR_MIRROR) &&
		(rf_page == dpcsr_pkg::PAGE_MIR0 ||
		rf_page == dpcsr_pkg::PAGE_MIR1)); // see RULE6
	assign rf_hi     = rf_page[0];
	assign rf_cfg_wr = take_rf && rf_we && rf_cfg_hit &&
		!cfg[dpcsr_pkg::BYTE_LOCK][dpcsr_pkg::LOCK_RF_BIT]; // see RULE3
	assign blk_cfg_wr = take_blk && i2c_we &&
		(i2c_block == dpcsr_pkg::BLOCK_CFG) &&
		!cfg[dpcsr_pkg::BYTE_LOCK][dpcsr_pkg::LOCK_I2C_BIT]; // see RULE3
	assign reg_wr    = take_reg && i2c_reg_we &&
		(i2c_reg_addr != dpcsr_pkg::BYTE_STATUS);
	// behaviour follows the session copy only
	assign ctrl      = ses[dpcsr_pkg::BYTE_CTRL]; // see RULE9 see RULE10
	assign msg_end   = ses[dpcsr_pkg::BYTE_MSGEND];
	// last page of an i2c block: four pages per block, 64 blocks a sector
	assign rf_last_page = take_rf && !rf_we &&
		(rf_sector == {1'b0, msg_end[6]}) &&
		(rf_page == {msg_end[5:0], 2'b11}); // see RULE17
	// power-on load sequencing
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			state <= dpcsr_pkg::DPCSR_LOAD;
		else
			state <= dpcsr_pkg::DPCSR_RUN;
	end
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			prefer_rf <= 1'b1;
		else if (take_rf && i2c_side)
			prefer_rf <= 1'b0;
		else if ((take_blk || take_reg) && rf_pend)
			prefer_rf <= 1'b1;
	end
	// default set storage, written only by the default-set paths
	always_ff @(posedge clk_sys)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (rf_cfg_wr) // see RULE1 see RULE2
				cfg[{rf_hi, i[1:0]}] <= rf_wdata[8*i +: 8];
		end
		for (int i = 0; i < 8; i++)
		begin
			if (blk_cfg_wr) // see RULE1 see RULE2
				cfg[i[2:0]] <= i2c_wdata[8*i +: 8];
		end
	end
	// session set: loaded from defaults, then written by i2c only
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < 8; i++)
				ses[i] <= dpcsr_pkg::SES_RESET;
		end
		else if (!run)
		begin
			for (int i = 0; i < 8; i++)
			begin
				// lock byte is not part of the session set
				if (i[2:0] != dpcsr_pkg::BYTE_LOCK) // see RULE7
					ses[i] <= cfg[i]; // see RULE8
			end
		end
		else if (reg_wr) // see RULE5 see RULE11
			ses[i2c_reg_addr] <= (ses[i2c_reg_addr] & ~i2c_reg_mask) |
				(i2c_reg_wdata & i2c_reg_mask);
	end
	// status byte held by hardware; read flag cleared by an i2c register read of the status byte
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			status <= dpcsr_pkg::STATUS_RESET;
		else
		begin
			if (field_on_evt)
				status[dpcsr_pkg::STAT_FIELD_BIT] <= 1'b1;
			else if (field_off_evt)
				status[dpcsr_pkg::STAT_FIELD_BIT] <= 1'b0;
			// set wins over the read clear
			if (rf_last_page)
				status[dpcsr_pkg::STAT_MSGREAD_BIT] <= 1'b1; // see RULE17
			else if (take_reg && !i2c_reg_we &&
				i2c_reg_addr == dpcsr_pkg::BYTE_STATUS)
				status[dpcsr_pkg::STAT_MSGREAD_BIT] <= 1'b0;
		end
	end
	// rf port answers
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rf_ack   <= 1'b0;
			rf_err   <= 1'b0;
			rf_rdata <= dpcsr_pkg::WORD_RESET;
		end
		else
		begin
			rf_ack <= take_rf;
			if (take_rf)
			begin
				rf_rdata <= dpcsr_pkg::WORD_RESET;
				rf_err   <= 1'b0;
				if (rf_cfg_hit)
				begin
					rf_err <= rf_we &&
						cfg[dpcsr_pkg::BYTE_LOCK][dpcsr_pkg::LOCK_RF_BIT];
					if (!rf_we)
						rf_rdata <= word_of(cfg[{rf_hi, 2'h0}],
							cfg[{rf_hi, 2'h1}], cfg[{rf_hi, 2'h2}],
							cfg[{rf_hi, 2'h3}]);
				end
				else if (rf_ses_hit)
				begin
					rf_err <= rf_we; // see RULE5 see RULE6
					if (!rf_we && rf_hi)
						rf_rdata <= word_of(ses[4], ses[5],
							status, ses[7]); // see RULE7
					else if (!rf_we)
						rf_rdata <= word_of(ses[0], ses[1], ses[2], ses[3]);
				end
				else
					rf_err <= 1'b1;
			end
		end
	end
	// i2c block answers: session block refused here
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			i2c_ack   <= 1'b0;
			i2c_err   <= 1'b0;
			i2c_rdata <= dpcsr_pkg::BLOCK_RESET;
		end
		else
		begin
			i2c_ack <= take_blk;
			if (take_blk)
			begin
				i2c_rdata <= dpcsr_pkg::BLOCK_RESET;
				i2c_err   <= (i2c_block != dpcsr_pkg::BLOCK_CFG) ||
					(i2c_we &&
					cfg[dpcsr_pkg::BYTE_LOCK][dpcsr_pkg::LOCK_I2C_BIT]);
				if (i2c_block == dpcsr_pkg::BLOCK_CFG && !i2c_we)
					i2c_rdata[63:0] <= {word_of(cfg[4], cfg[5], cfg[6],
						cfg[7]), word_of(cfg[0], cfg[1], cfg[2], cfg[3])};
			end
		end
	end
	// i2c register operation answers
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			i2c_reg_ack   <= 1'b0;
			i2c_reg_rdata <= dpcsr_pkg::SES_RESET;
		end
		else
		begin
			i2c_reg_ack <= take_reg;
			if (take_reg && i2c_reg_addr == dpcsr_pkg::BYTE_STATUS)
				i2c_reg_rdata <= status;
			else if (take_reg)
				i2c_reg_rdata <= ses[i2c_reg_addr];
		end
	end
	// control outputs from the session control byte
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rf_mute_softreset_enable <= 1'b0;
			relay_mode_enable        <= 1'b0;
			soft_reset_pulse         <= 1'b0;
		end
		else
		begin
			rf_mute_softreset_enable <= ctrl[dpcsr_pkg::CTRL_MUTE_BIT]; // see RULE12
			relay_mode_enable <= ctrl[dpcsr_pkg::CTRL_RELAY_BIT]; // see RULE13
			soft_reset_pulse  <= ctrl[dpcsr_pkg::CTRL_MUTE_BIT] &&
				i2c_rep_start_evt; // see RULE12
		end
	end
	// field detect pin: open drain, driven low while asserted
	logic [1:0]                 asel;
	logic [1:0]                 rsel;
	logic                       dir_rf_to_i2c;
	logic                       fd_set;
	logic                       fd_clr;
	assign asel = ctrl[dpcsr_pkg::CTRL_ASSERT_LSB +: 2];
	assign rsel = ctrl[dpcsr_pkg::CTRL_REL_LSB +: 2];
	assign dir_rf_to_i2c = ctrl[dpcsr_pkg::CTRL_DIR_BIT];
	always_comb
	begin
		unique case (asel) // see RULE16
			dpcsr_pkg::SEL_FIELD: fd_set = field_on_evt;
			dpcsr_pkg::SEL_ALT1:  fd_set = soc_evt;
			dpcsr_pkg::SEL_ALT2:  fd_set = select_evt;
			dpcsr_pkg::SEL_RELAY: fd_set = dir_rf_to_i2c ?
				relay_ready_evt : relay_taken_evt;
		endcase
		unique case (rsel) // see RULE14
			dpcsr_pkg::SEL_FIELD: fd_clr = field_off_evt;
			dpcsr_pkg::SEL_ALT1:  fd_clr = field_off_evt || halt_evt;
			dpcsr_pkg::SEL_ALT2:  fd_clr = field_off_evt || rf_last_page;
			dpcsr_pkg::SEL_RELAY: fd_clr = field_off_evt ||
				((asel == dpcsr_pkg::SEL_RELAY) && (dir_rf_to_i2c ?
				i2c_last_read_evt : i2c_last_write_evt)); // see RULE15
		endcase
	end
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			field_detect_output_oe <= 1'b0;
			field_detect_output_o  <= 1'b0;
		end
		else
		begin
			field_detect_output_o <= 1'b0;
			// a release event beats a simultaneous assert
			if (fd_clr)
				field_detect_output_oe <= 1'b0;
			else if (fd_set)
				field_detect_output_oe <= 1'b1;
		end
	end
endmodule // dpcsr_regs

// [dv/dpcsr_regs_monitor.sv]
// concurrent checks on the register bank ports
// assumes it is bound into dpcsr_regs from the bench top
`timescale 1ns/1ps
module dpcsr_regs_monitor
(
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic       rf_we,
	input wire logic [1:0] rf_sector,
	input wire logic [7:0] rf_page,
	input wire logic       rf_ack,
	input wire logic       rf_err,
	input wire logic [7:0] i2c_block,
	input wire logic       i2c_ack,
	input wire logic       i2c_err,
	input wire logic       i2c_reg_we,
	input wire logic [2:0] i2c_reg_addr,
	input wire logic [7:0] i2c_reg_mask,
	input wire logic [7:0] i2c_reg_wdata,
	input wire logic       i2c_reg_ack,
	input wire logic       field_off_evt,
	input wire logic       i2c_rep_start_evt,
	input wire logic       rf_mute_softreset_enable,
	input wire logic       relay_mode_enable,
	input wire logic       soft_reset_pulse,
	input wire logic       field_detect_output_o,
	input wire logic       field_detect_output_oe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_rf_ack_pulse: assert property (rf_ack |=> !rf_ack)
		else $error("rf ack longer than one cycle");
	a_session_rf_ro: assert property (rf_ack && $past(rf_we &&
		rf_sector == 2'h0 && rf_page inside {8'hec, 8'hed}) |-> rf_err)
		else $error("rf session write accepted");
	a_mirror_rf_ro: assert property (rf_ack && $past(rf_we &&
		rf_sector == 2'h3 && rf_page inside {8'hf8, 8'hf9}) |-> rf_err)
		else $error("rf mirror write accepted");
	a_config_rf_read: assert property (rf_ack && $past(!rf_we &&
		rf_sector == 2'h0 && rf_page == 8'he8) |-> !rf_err)
		else $error("rf default read refused");
	a_session_no_block: assert property (
		i2c_ack && $past(i2c_block == 8'hfe) |-> i2c_err)
		else $error("session reached by block transfer");
	a_relay_follows: assert property (i2c_reg_ack && $past(
		i2c_reg_we && i2c_reg_addr == 3'h0 && i2c_reg_mask[6]) |=>
		relay_mode_enable == $past(i2c_reg_wdata[6], 2))
		else $error("relay enable not updated");
	a_mute_follows: assert property (i2c_reg_ack && $past(
		i2c_reg_we && i2c_reg_addr == 3'h0 && i2c_reg_mask[7]) |=>
		rf_mute_softreset_enable == $past(i2c_reg_wdata[7], 2))
		else $error("mute enable not updated");
	a_soft_reset_gate: assert property (i2c_rep_start_evt |=>
		soft_reset_pulse == $past(rf_mute_softreset_enable))
		else $error("soft reset pulse wrong");
	a_field_off_release: assert property (
		field_off_evt |=> !field_detect_output_oe)
		else $error("field pin not released");
	a_pin_drives_low: assert property (!field_detect_output_o)
		else $error("field pin data high");
endmodule // dpcsr_regs_monitor

// [dv/dpcsr_reader_model.sv]
// rf reader model: one page read or write at a time
// assumes the bank answers with a one cycle rf_ack pulse
`timescale 1ns/1ps
module dpcsr_reader_model
(
	input  wire logic        clk_sys,
	input  wire logic        rf_ack,
	input  wire logic        rf_err,
	input  wire logic [31:0] rf_rdata,
	output logic             rf_req,
	output logic             rf_we,
	output logic [1:0]       rf_sector,
	output logic [7:0]       rf_page,
	output logic [31:0]      rf_wdata
);
	initial {rf_req, rf_we, rf_sector, rf_page, rf_wdata} = '0;
	// hold until answered, then leave inverted qualifiers behind
	task automatic xfer(input logic w, input logic [1:0] s,
		input logic [7:0] p, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(negedge clk_sys);
		{rf_req, rf_we, rf_sector, rf_page, rf_wdata} = {1'b1, w, s, p, d};
		for (int n = 0; n < 50 && !rf_ack; n++)
			@(negedge clk_sys);
		{rd, er} = {rf_rdata, rf_err | !rf_ack};
		{rf_req, rf_we, rf_sector, rf_page, rf_wdata} = ~{1'b1, w, s, p, d};
		@(negedge clk_sys);
	endtask
endmodule // dpcsr_reader_model

// [dv/test_dpcsr_regs.sv]
// self-checking bench for the dual port register bank
// assumes the reader model drives the rf port, i2c driven here
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		n_compared++; \
		if ((a) !== (b)) \
		begin \
			fails++; \
			$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); \
		end \
	end
module test_dpcsr_regs;
	localparam logic [63:0] CFG = 64'h5afc_1122_3344_02c0;
	localparam int ASEL[4] = '{0, 2, 3, 5};
	logic         clk_sys, rst_b, rf_req, rf_we, rf_ack, rf_err, e;
	logic [1:0]   rf_sector;
	logic [7:0]   rf_page, i2c_block, rb;
	logic [31:0]  rf_wdata, rf_rdata, rw;
	logic         i2c_req, i2c_we, i2c_ack, i2c_err;
	logic [127:0] i2c_wdata, i2c_rdata, bw;
	logic         i2c_reg_req, i2c_reg_we, i2c_reg_ack;
	logic [2:0]   i2c_reg_addr;
	logic [7:0]   i2c_reg_mask, i2c_reg_wdata, i2c_reg_rdata;
	logic [9:0]   evt;
	logic         rf_mute_softreset_enable, relay_mode_enable;
	logic         soft_reset_pulse, fd_o, fd_oe;
	int           fails = 0, n_compared = 0, cycles = 0;
	dpcsr_reader_model rdr
	(
		.clk_sys, .rf_ack, .rf_err, .rf_rdata, .rf_req, .rf_we,
		.rf_sector, .rf_page, .rf_wdata
	);
	dpcsr_regs dut
	(
		.clk_sys, .rst_b, .rf_req, .rf_we, .rf_sector, .rf_page, .rf_wdata,
		.rf_ack, .rf_err, .rf_rdata, .i2c_req, .i2c_we, .i2c_block,
		.i2c_wdata, .i2c_ack, .i2c_err, .i2c_rdata, .i2c_reg_req,
		.i2c_reg_we, .i2c_reg_addr, .i2c_reg_mask, .i2c_reg_wdata,
		.i2c_reg_ack, .i2c_reg_rdata, .field_on_evt(evt[0]),
		.field_off_evt(evt[1]), .soc_evt(evt[2]), .select_evt(evt[3]),
		.halt_evt(evt[4]), .relay_ready_evt(evt[5]),
		.relay_taken_evt(evt[6]), .i2c_last_read_evt(evt[7]),
		.i2c_last_write_evt(evt[8]), .i2c_rep_start_evt(evt[9]),
		.rf_mute_softreset_enable, .relay_mode_enable, .soft_reset_pulse,
		.field_detect_output_o(fd_o), .field_detect_output_oe(fd_oe)
	);
	task automatic conclude;
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic rst;
		rst_b = 1'b0;
		repeat (16) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic rf(input logic w, input logic [1:0] s,
		input logic [7:0] p, input logic [31:0] d);
		rdr.xfer(w, s, p, d, rw, e);
	endtask
	task automatic blk(input logic w, input logic [7:0] a,
		input logic [127:0] d);
		@(negedge clk_sys);
		{i2c_req, i2c_we, i2c_block, i2c_wdata} = {1'b1, w, a, d};
		for (int n = 0; n < 50 && !i2c_ack; n++)
			@(negedge clk_sys);
		{bw, e} = {i2c_rdata, i2c_err | !i2c_ack};
		{i2c_req, i2c_we, i2c_block, i2c_wdata} = ~{1'b1, w, a, d};
		@(negedge clk_sys);
	endtask
	task automatic rop(input logic w, input logic [2:0] a,
		input logic [7:0] m, input logic [7:0] d);
		@(negedge clk_sys);
		{i2c_reg_req, i2c_reg_we, i2c_reg_addr, i2c_reg_mask,
			i2c_reg_wdata} = {1'b1, w, a, m, d};
		for (int n = 0; n < 50 && !i2c_reg_ack; n++)
			@(negedge clk_sys);
		rb = i2c_reg_rdata;
		{i2c_reg_req, i2c_reg_we, i2c_reg_addr, i2c_reg_mask,
			i2c_reg_wdata} = ~{1'b1, w, a, m, d};
		@(negedge clk_sys);
	endtask
	task automatic ev(input int i, input logic x);
		@(negedge clk_sys);
		evt[i] = 1'b1;
		@(negedge clk_sys);
		evt[i] = 1'b0;
		`CHK(fd_oe, x)
	endtask
	task automatic t_config;
		blk(1'b1, dpcsr_pkg::BLOCK_CFG, 128'h0);
		rst();
		blk(1'b1, dpcsr_pkg::BLOCK_CFG, {64'h0, CFG});
		`CHK(relay_mode_enable, 1'b0)
		rf(1'b0, dpcsr_pkg::SECTOR_MAIN, dpcsr_pkg::PAGE_CFG1, 32'h0);
		`CHK(rw, CFG[63:32])
		rst();
		rf(1'b0, dpcsr_pkg::SECTOR_MAIN, dpcsr_pkg::PAGE_SES0, 32'h0);
		`CHK(rw, CFG[31:0])
		rf(1'b0, dpcsr_pkg::SECTOR_MIRROR, dpcsr_pkg::PAGE_MIR1, 32'h0);
		`CHK(rw, 32'h5a00_1122)
		`CHK({rf_mute_softreset_enable, relay_mode_enable}, 2'b11)
		rf(1'b1, dpcsr_pkg::SECTOR_MAIN, dpcsr_pkg::PAGE_CFG0, 32'h3344_0200);
		`CHK(e, 1'b0)
		blk(1'b0, dpcsr_pkg::BLOCK_CFG, 128'h0);
		`CHK(bw[31:0], 32'h3344_0200)
		`CHK(relay_mode_enable, 1'b1)
	endtask
	task automatic t_session;
		rop(1'b1, 3'h0, 8'h40, 8'h00);
		`CHK({rf_mute_softreset_enable, relay_mode_enable}, 2'b10)
		rf(1'b1, dpcsr_pkg::SECTOR_MAIN, dpcsr_pkg::PAGE_SES0, 32'h0);
		`CHK(e, 1'b1)
		rf(1'b0, dpcsr_pkg::SECTOR_MIRROR, dpcsr_pkg::PAGE_MIR0, 32'h0);
		`CHK(rw[7:0], 8'h80)
		blk(1'b0, dpcsr_pkg::BLOCK_SES, 128'h0);
		`CHK(e, 1'b1)
		rop(1'b0, 3'h0, 8'h00, 8'h00);
		`CHK(rb, 8'h80)
		ev(9, fd_oe);
		`CHK(soft_reset_pulse, 1'b1)
		rst();
		`CHK({rf_mute_softreset_enable, relay_mode_enable}, 2'b00)
	endtask
	task automatic t_fd;
		for (int s = 0; s < 4; s++)
		begin
			rop(1'b1, 3'h0, 8'hff, 8'h01 | 8'(s << 2));
			ev(ASEL[s], 1'b1);
			ev(1, 1'b0);
		end
		rop(1'b1, 3'h0, 8'hff, 8'h10);
		ev(0, 1'b1);
		ev(4, 1'b0);
		rop(1'b1, 3'h0, 8'hff, 8'h3d);
		ev(5, 1'b1);
		ev(7, 1'b0);
		rop(1'b1, 3'h0, 8'hff, 8'h3c);
		ev(6, 1'b1);
		ev(8, 1'b0);
		rop(1'b1, 3'h0, 8'hff, 8'h30);
		ev(0, 1'b1);
		ev(7, 1'b1);
		rop(1'b1, 3'h0, 8'hff, 8'h20);
		rop(1'b1, 3'h1, 8'hff, 8'h03);
		rf(1'b0, dpcsr_pkg::SECTOR_MAIN, 8'h0f, 32'h0);
		@(negedge clk_sys);
		`CHK(fd_oe, 1'b0)
		rop(1'b0, 3'h6, 8'h00, 8'h00);
		`CHK(rb[1], 1'b1)
	endtask
	task automatic t_locks;
		blk(1'b1, dpcsr_pkg::BLOCK_CFG, {64'h0, 64'h0001_0000_0000_0000});
		rf(1'b1, dpcsr_pkg::SECTOR_MAIN, dpcsr_pkg::PAGE_CFG0, 32'h0);
		`CHK(e, 1'b1)
		rf(1'b0, dpcsr_pkg::SECTOR_MAIN, dpcsr_pkg::PAGE_CFG0, 32'h0);
		`CHK(e, 1'b0)
		`CHK(rw, 32'h0000_0000)
		blk(1'b1, dpcsr_pkg::BLOCK_CFG, {64'h0, 64'h0003_0000_0000_0000});
		`CHK(e, 1'b0)
		blk(1'b1, dpcsr_pkg::BLOCK_CFG, 128'h0);
		`CHK(e, 1'b1)
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		{i2c_req, i2c_we, i2c_block, i2c_wdata, evt} = '0;
		{i2c_reg_req, i2c_reg_we, i2c_reg_addr, i2c_reg_mask} = '0;
		i2c_reg_wdata = 8'h00;
		rst();
		t_config();
		t_session();
		t_fd();
		t_locks();
		conclude();
	end
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			conclude();
		end
	end
endmodule // test_dpcsr_regs
bind dpcsr_regs dpcsr_regs_monitor mon
(
	.clk_sys, .rst_b, .rf_we, .rf_sector, .rf_page, .rf_ack, .rf_err,
	.i2c_block, .i2c_ack, .i2c_err, .i2c_reg_we, .i2c_reg_addr,
	.i2c_reg_mask, .i2c_reg_wdata, .i2c_reg_ack, .field_off_evt,
	.i2c_rep_start_evt, .rf_mute_softreset_enable, .relay_mode_enable,
	.soft_reset_pulse, .field_detect_output_o, .field_detect_output_oe
);
